// ### logic/evsf_top.v
// Event status and operation error flags with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "evsf_consts.vh"
module evsf_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        op_start,
  input  wire        op_is_erase,
  input  wire        op_protected,
  input  wire        op_done,
  input  wire        op_fail,
  input  wire        ecc2_detect,
  input  wire        ecc1_correct,
  input  wire        clear_status_command,
  output reg         busy_flag,
  output reg         op_refused,
  output reg         int_n_o,
  output reg         int_n_oe
);
  // Operation state
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  // Event inputs may come from the array timing domain, so synchronise
  wire [6:0] ev_sync;
  evsf_sync2 #(
    .WIDTH (7)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({op_start, op_is_erase, op_protected, op_done, op_fail, ecc2_detect, ecc1_correct}),
    .sync_out (ev_sync)
  );
  wire s_start   = ev_sync[6];
  wire s_erase   = ev_sync[5];
  wire s_prot    = ev_sync[4];
  wire s_done    = ev_sync[3];
  wire s_fail    = ev_sync[2];
  wire s_ecc2    = ev_sync[1];
  wire s_ecc1    = ev_sync[0];

  wire [0:0] clr_sync;
  evsf_sync2 #(
    .WIDTH (1)
  ) u_sync_clr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (clear_status_command),
    .sync_out (clr_sync)
  );

  // Edge detect on synchronised levels only
  reg [3:0] prev_ff;
  wire      start_pulse = s_start & ~prev_ff[3];
  wire      done_pulse  = s_done  & ~prev_ff[2];
  wire      ecc2_pulse  = s_ecc2  & ~prev_ff[1];
  wire      ecc1_pulse  = s_ecc1  & ~prev_ff[0];

  // Bus state
  reg                    dphase_ff;
  reg                    dwrite_ff;
  reg [`EVSF_ADDR_W-1:0] daddr_ff;

  reg [15:0] event_ff;
  reg [15:0] config_ff;
  reg        program_error_flag_ff;
  reg        erase_error_flag_ff;
  reg        op_erase_ff;
  reg [2:0]  state_ff;

  reg [15:0] nxt_event;
  reg        nxt_program_error_flag;
  reg        nxt_erase_error_flag;
  reg [2:0]  nxt_state;
  reg        nxt_busy;
  reg        nxt_refused;
  reg        nxt_int_n;
  reg [31:0] nxt_rdata;

  function addr_hit;
    input [`EVSF_ADDR_W-1:0] a;
    input [`EVSF_ADDR_W-1:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // An event records only while its own select bit and the pin disable bit are 0
  function ev_armed;
    input [15:0]  cfg;
    input integer pos;
    begin
      ev_armed = ~cfg[pos] & ~cfg[`EVSF_BIT_INTDIS];
    end
  endfunction

  function [31:0] status_word;
    input prg;
    input ers;
    input bsy;
    begin
      // Write-enable bit 1 lives outside this block and reads 0 here
      status_word = {24'h000000, 1'b0, prg, ers, 3'b000, 1'b0, bsy};
    end
  endfunction

  wire addr_take = hsel & hready & htrans[1];
  wire wr_event  = dphase_ff & dwrite_ff & addr_hit(daddr_ff, `EVSF_OFF_EVENT);
  wire wr_config = dphase_ff & dwrite_ff & addr_hit(daddr_ff, `EVSF_OFF_CONFIG);
  wire wr_clear  = dphase_ff & dwrite_ff & addr_hit(daddr_ff, `EVSF_OFF_CONTROL) & hwdata[`EVSF_BIT_CLR];
  wire do_clear  = wr_clear | clr_sync[0];
  wire int_en    = ~config_ff[`EVSF_BIT_INTDIS];
  // Busy-to-ready only on a clean finish; a failed operation stays busy
  wire rdy_ev    = done_pulse & (state_ff == ST_RUN) & ~s_fail & ev_armed(config_ff, `EVSF_BIT_RDY);
  wire ecc2_ev   = ecc2_pulse & ev_armed(config_ff, `EVSF_BIT_ECC2);
  wire ecc1_ev   = ecc1_pulse & ev_armed(config_ff, `EVSF_BIT_ECC1);

  // Event flags: set wins over clear, reset value all ones
  always @* begin
    nxt_event = event_ff;
    if (wr_event) begin
      // Writing 1 restores a bit to its idle level
      nxt_event = event_ff | (hwdata[15:0] | `EVSF_EVENT_RSV_MASK);
    end
    if (do_clear) begin
      nxt_event = `EVSF_EVENT_RESET;
    end
    if (rdy_ev) begin
      nxt_event[`EVSF_BIT_RDY] = 1'b0;
    end
    if (ecc2_ev) begin
      nxt_event[`EVSF_BIT_ECC2] = 1'b0;
    end
    if (ecc1_ev) begin
      nxt_event[`EVSF_BIT_ECC1] = 1'b0;
    end
  end

  // Error flags and operation sequencing
  always @* begin
    nxt_program_error_flag  = program_error_flag_ff;
    nxt_erase_error_flag  = erase_error_flag_ff;
    nxt_state   = state_ff;
    nxt_refused = 1'b0;
    if (do_clear) begin
      nxt_program_error_flag = 1'b0;
      nxt_erase_error_flag = 1'b0;
    end
    case (state_ff)
      ST_IDLE: begin
        if (start_pulse) begin
          if (s_prot) begin
            nxt_program_error_flag = nxt_program_error_flag | ~s_erase;
            nxt_erase_error_flag = nxt_erase_error_flag | s_erase;
            nxt_state  = ST_HOLD;
          end else begin
            nxt_state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (done_pulse) begin
          // Success leaves a fresh flag at 0, failure sets it
          if (op_erase_ff) begin
            nxt_erase_error_flag = s_fail | (erase_error_flag_ff & ~do_clear);
          end else begin
            nxt_program_error_flag = s_fail | (program_error_flag_ff & ~do_clear);
          end
          nxt_state = s_fail ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (start_pulse) begin
          nxt_refused = 1'b1;
        end
        if (!nxt_program_error_flag && !nxt_erase_error_flag) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (state_ff == ST_RUN && start_pulse) begin
      nxt_refused = 1'b1;
    end
    nxt_busy  = (nxt_state != ST_IDLE) | nxt_program_error_flag | nxt_erase_error_flag;
    // Output low while any enabled event bit is recorded
    nxt_int_n = ~(int_en & (~nxt_event[`EVSF_BIT_RDY] | ~nxt_event[`EVSF_BIT_ECC2]
                            | ~nxt_event[`EVSF_BIT_ECC1]));
  end

  // Read mux for the data phase that starts next cycle
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[`EVSF_ADDR_W-1:0])
      `EVSF_OFF_EVENT:   nxt_rdata = {16'h0000, nxt_event};
      `EVSF_OFF_STATUS1: nxt_rdata = status_word(nxt_program_error_flag, nxt_erase_error_flag, nxt_busy);
      `EVSF_OFF_CONFIG:  nxt_rdata = {16'h0000, config_ff};
      `EVSF_OFF_ID:      nxt_rdata = `EVSF_ID_VALUE;
      default:           nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Edge history of the synchronised levels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= 4'h0;
    end else begin
      prev_ff <= {s_start, s_done, s_ecc2, s_ecc1};
    end
  end

  // Address phase is captured only while the bus is ready
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_ff <= 1'b0;
      dwrite_ff <= 1'b0;
      daddr_ff  <= {`EVSF_ADDR_W{1'b0}};
    end else if (hready) begin
      dphase_ff <= addr_take;
      dwrite_ff <= hwrite;
      daddr_ff  <= haddr[`EVSF_ADDR_W-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (addr_take && !hwrite) begin
        hrdata <= nxt_rdata;
      end
      // Zero wait states, every transfer is OKAY
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Config write lands at the end of its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_ff <= `EVSF_CONFIG_RESET;
    end else if (wr_config) begin
      config_ff <= hwdata[15:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_ff <= `EVSF_EVENT_RESET;
    end else begin
      event_ff <= nxt_event;
    end
  end

  // Start latches its kind so completion updates the right flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_error_flag_ff   <= 1'b0;
      erase_error_flag_ff   <= 1'b0;
      op_erase_ff <= 1'b0;
      state_ff    <= ST_IDLE;
    end else begin
      if (state_ff == ST_IDLE && start_pulse) begin
        op_erase_ff <= s_erase;
      end
      program_error_flag_ff <= nxt_program_error_flag;
      erase_error_flag_ff <= nxt_erase_error_flag;
      state_ff  <= nxt_state;
    end
  end

  // Status and pin outputs come straight from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_flag  <= 1'b0;
      op_refused <= 1'b0;
      int_n_o    <= 1'b0;
      int_n_oe   <= 1'b0;
    end else begin
      busy_flag  <= nxt_busy;
      op_refused <= nxt_refused;
      // Open drain: the level stays low, only the enable moves
      int_n_o    <= 1'b0;
      int_n_oe   <= ~nxt_int_n;
    end
  end
endmodule // evsf_top
`default_nettype wire

// ### logic/evsf_consts.vh
// Constants for the event and error status flag block
`ifndef EVSF_CONSTS_VH
`define EVSF_CONSTS_VH
`define EVSF_ADDR_W          12
`define EVSF_OFF_EVENT       12'h000
`define EVSF_OFF_STATUS1     12'h004
`define EVSF_OFF_CONFIG      12'h008
`define EVSF_OFF_CONTROL     12'h00c
`define EVSF_OFF_ID          12'h010
`define EVSF_BIT_RDY         4
`define EVSF_BIT_ECC2        1
`define EVSF_BIT_ECC1        0
`define EVSF_BIT_PROGRAM_ERROR_FLAG      6
`define EVSF_BIT_ERASE_ERROR_FLAG      5
`define EVSF_BIT_BUSY        0
`define EVSF_BIT_INTDIS      15
`define EVSF_BIT_CLR         0
`define EVSF_EVENT_RESET     16'hffff
`define EVSF_CONFIG_RESET    16'hffff
`define EVSF_EVENT_RSV_MASK  16'hffec
`define EVSF_ID_VALUE        32'h0000_5a01
`define EVSF_HTRANS_NONSEQ   2'b10
`define EVSF_HTRANS_SEQ      2'b11
`endif

// ### logic/evsf_sync2.v
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module evsf_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // evsf_sync2
`default_nettype wire

// ### sim/evsf_props.sv
// Port checker for the event and error flag block
`timescale 1ns/1ps
`default_nettype none
module evsf_props (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       op_start,
  input wire logic       op_done,
  input wire logic       op_fail,
  input wire logic       clear_status_command,
  input wire logic       busy_flag,
  input wire logic       op_refused,
  input wire logic       int_n_o,
  input wire logic       int_n_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_fail_done; $rose(op_done) && op_fail && busy_flag; endsequence
  sequence s_no_clear; (!clear_status_command && !(hwrite && htrans[1])) [*6]; endsequence
  a_int_open_drain: assert property (int_n_o == 1'b0) else $error("int driven high");
  a_reset_quiet: assert property ($rose(hresetn) |-> !busy_flag && !int_n_oe) else $error("not idle");
  a_refuse_busy: assert property (op_refused |-> $past(busy_flag)) else $error("refused when idle");
  a_refuse_once: assert property (op_refused |=> !op_refused) else $error("long refusal");
  a_refuse_cause: assert property (op_refused |-> $past(op_start, 3) || $past(op_start, 4))
    else $error("refusal without start");
  a_start_busy: assert property ($rose(op_start) && !busy_flag |-> ##[1:6] busy_flag)
    else $error("start not busy");
  a_fail_keeps_busy: assert property (s_fail_done ##1 s_no_clear |-> busy_flag)
    else $error("standby with error");
  // Only a bus write or the clear input may release the pin
  a_int_held: assert property ($fell(int_n_oe) |-> $past(hwrite && htrans[1], 2) || $past(hwrite && htrans[1], 3)
    || $past(clear_status_command, 3) || $past(clear_status_command, 4))
    else $error("int dropped");
endmodule // evsf_props
bind evsf_top evsf_props u_props (.hclk, .hresetn, .htrans, .hwrite, .op_start, .op_done, .op_fail,
  .clear_status_command, .busy_flag, .op_refused, .int_n_o, .int_n_oe);
`default_nettype wire

// ### sim/evsf_op_engine.sv
// Array operation engine model: answers a start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module evsf_op_engine #(
  parameter int DLY = 6
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic op_start,
  input  wire logic fail_cmd,
  output var  logic op_done,
  output wire logic op_fail
);
  logic [3:0] cnt_ff;
  logic       start_ff;
  // Inverse outside done so a stale result is never read
  assign op_fail = op_done ? fail_cmd : ~fail_cmd;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff   <= 4'h0;
      start_ff <= 1'b0;
      op_done  <= 1'b0;
    end else begin
      start_ff <= op_start;
      cnt_ff   <= (op_start && !start_ff) ? DLY[3:0] : cnt_ff - {3'h0, cnt_ff != 4'h0};
      op_done  <= cnt_ff == 4'h1 || cnt_ff == 4'h2;
    end
  end
endmodule // evsf_op_engine
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the event and error flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  logic [3:0]  pins = 4'h0; // Erase, protected, fail, start
  logic [2:0]  evt = 3'h0;  // Clear, double, single
  logic [31:0] hrdata;
  logic        hreadyout, hresp, op_done, op_fail, busy_flag, op_refused, int_n_o, int_n_oe;
  int          fails = 0;
  int          check_count = 0;
  int          refusals = 0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (op_refused === 1'b1) refusals++;
  evsf_top i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_start(pins[0]), .op_is_erase(pins[3]),
    .op_protected(pins[2]), .op_done, .op_fail, .ecc2_detect(evt[1]), .ecc1_correct(evt[0]),
    .clear_status_command(evt[2]), .busy_flag, .op_refused, .int_n_o, .int_n_oe);
  evsf_op_engine i_eng (.hclk, .hresetn, .op_start(pins[0]), .fail_cmd(pins[1]), .op_done, .op_fail);
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 40) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    q = hrdata;
    guard(n);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Idle edge so a following read sees the landed write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(posedge hclk);
  endtask
  task automatic pulse(input logic [2:0] m);
    evt <= m;
    repeat (2) @(posedge hclk);
    evt <= 3'h0;
    repeat (5) @(posedge hclk);
  endtask
  task automatic run_op(input logic [2:0] epf);
    int n = 0;
    pins <= {epf, 1'b1};
    do begin
      @(posedge hclk);
      n++;
    end while (op_done !== 1'b1 && n < 40);
    pins <= {epf, 1'b0};
    guard(n);
    repeat (5) @(posedge hclk);
  endtask
  task automatic t_reset();
    rd(12'h000, 32'hffff);
    rd(12'h004, 32'h0);
    rd(12'h020, 32'h0);
    chk({27'h0, hreadyout, hresp, busy_flag, int_n_oe, int_n_o}, 32'h10);
  endtask
  task automatic t_events();
    pulse(3'h1);
    rd(12'h000, 32'hffff);
    wr(12'h008, 32'h7fec);
    pulse(3'h1);
    rd(12'h000, 32'hfffe);
    pulse(3'h2);
    rd(12'h000, 32'hfffc);
    chk({31'h0, int_n_oe}, 32'h1);
    wr(12'h000, 32'hffff);
    rd(12'h000, 32'hffff);
    chk({31'h0, int_n_oe}, 32'h0);
  endtask
  task automatic t_ops();
    run_op(3'b000);
    rd(12'h000, 32'hffef);
    rd(12'h004, 32'h0);
    wr(12'h000, 32'hffff);
    wr(12'h008, 32'h7ffc);
    run_op(3'b100);
    rd(12'h000, 32'hffff);
    rd(12'h004, 32'h0);
    for (int k = 0; k < 4; k++) begin
      run_op({k[0], k[1], ~k[1]});
      rd(12'h004, k[0] ? 32'h21 : 32'h41);
      run_op(3'b000);
      chk(refusals, k + 1);
      rd(12'h004, k[0] ? 32'h21 : 32'h41);
      if (k[1]) wr(12'h00c, 32'h1);
      else pulse(3'h4);
      rd(12'h004, 32'h0);
    end
  endtask
  // Failed program leaves the ready bit alone; a reset while the error holds clears everything
  task automatic t_rearm();
    wr(12'h008, 32'h7fec);
    run_op(3'b001);
    pulse(3'h1);
    rd(12'h000, 32'hfffe);
    rd(12'h004, 32'h41);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({30'h0, busy_flag, int_n_oe}, 32'h0);
    rd(12'h000, 32'hffff);
    rd(12'h004, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_events();
    t_ops();
    t_rearm();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
